// ### hdl/gate_scan_pkg.sv
// Shared constants for the gate scan shift register
package gate_scan_pkg;
	localparam int   STAGE_COUNT = 120;
	localparam logic STAGE_RST   = 1'b0;
	localparam logic SERIAL_RST  = 1'b0;
	localparam logic GATE_OFF    = 1'b0;
	localparam logic PIN_DRIVE   = 1'b0;
	localparam logic PIN_FLOAT   = 1'b1;
	localparam logic DIR_UP      = 1'b1;
endpackage

// ### hdl/shift_clock_edge.sv
// Rising and falling edge pulses of the sampled shift clock
`timescale 1ns/1ps
module shift_clock_edge (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic level_i,
	output logic      rise_o,
	output logic      fall_o
);
	import gate_scan_pkg::*;

	logic level_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			level_q <= STAGE_RST;
		end else begin
			level_q <= level_i;
		end
	end

	// The level after reset counts as low, so a high clock at release
	// yields one rising pulse; the controller starts frames with it low
	assign rise_o = level_i & ~level_q;
	assign fall_o = ~level_i & level_q;
endmodule // shift_clock_edge

// ### hdl/gate_scan_shift_register.sv
// 120-stage bidirectional gate scan shift register
// Contract
// - Sample entry pin into first stage on rise
// - Each stage takes predecessor on every rise
// - Serial output changes only on falling edge
// - Entered bit leaves after 120 shifts
// - Each gate output mirrors one stage, parallel
// - Select high: pin a in, b out, upward
// - Select low: pin b in, a out, downward
// - Clear high forces all gate outputs low
// - Clear low: gate outputs follow stages
`timescale 1ns/1ps
module gate_scan_shift_register #(
	parameter int STAGES = gate_scan_pkg::STAGE_COUNT
) (
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              shift_clock_i,
	input  wire logic              direction_select_i,
	input  wire logic              output_clear_i,
	input  wire logic              serial_pin_a_i,
	output logic                   serial_pin_a_o,
	output logic                   serial_pin_a_oe_b_o,
	input  wire logic              serial_pin_b_i,
	output logic                   serial_pin_b_o,
	output logic                   serial_pin_b_oe_b_o,
	output logic [STAGES-1:0]      gate_outputs_o
);
	import gate_scan_pkg::*;

	// Both end stages need a distinct neighbour to shift from
	if (STAGES < 2) begin : g_bad_stages
		$error("STAGES must be at least 2");
	end

	logic              rise;
	logic              fall;
	logic              dir_up;
	logic [STAGES-1:0] stage_q;
	logic [STAGES-1:0] stage_d;
	logic              serial_out_q;
	logic [STAGES-1:0] gate_q;

	assign dir_up = (direction_select_i == DIR_UP);

	shift_clock_edge u_edge (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.level_i (shift_clock_i),
		.rise_o  (rise),
		.fall_o  (fall)
	);

	// Next value of every stage; end stages load the entry pin
	generate
		for (genvar i = 0; i < STAGES; i++) begin : g_stage
			logic from_low;
			logic from_high;
			if (i == 0) begin : g_first
				assign from_low = serial_pin_a_i;
			end else begin : g_mid_lo
				assign from_low = stage_q[i-1];
			end
			if (i == STAGES - 1) begin : g_last
				assign from_high = serial_pin_b_i;
			end else begin : g_mid_hi
				assign from_high = stage_q[i+1];
			end
			assign stage_d[i] = dir_up ? from_low : from_high;
		end
	endgenerate

	// Shifting ignores the clear input so the scan keeps its place
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stage_q <= {STAGES{STAGE_RST}};
		end else if (rise) begin
			stage_q <= stage_d;
		end
	end

	// Far-end pin is refreshed on the falling edge so a cascaded part
	// sampling on the next rise sees settled data
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			serial_out_q <= SERIAL_RST;
		end else if (fall) begin
			serial_out_q <= dir_up ? stage_q[STAGES-1] : stage_q[0];
		end
	end

	// Clear is registered with the stages so all outputs drop together
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gate_q <= {STAGES{GATE_OFF}};
		end else if (output_clear_i) begin
			gate_q <= {STAGES{GATE_OFF}};
		end else begin
			gate_q <= stage_q;
		end
	end

	assign gate_outputs_o      = gate_q;
	assign serial_pin_a_o      = serial_out_q;
	assign serial_pin_b_o      = serial_out_q;
	assign serial_pin_a_oe_b_o = dir_up ? PIN_FLOAT : PIN_DRIVE;
	assign serial_pin_b_oe_b_o = dir_up ? PIN_DRIVE : PIN_FLOAT;

	property p_entry_up;
		@(posedge clk_i) disable iff (!rst_b_i)
		rise && dir_up |=> stage_q[0] == $past(serial_pin_a_i);
	endproperty
	a_entry_up: assert property (p_entry_up)
		else $error("pin a not captured into first stage");

	property p_shift_up;
		@(posedge clk_i) disable iff (!rst_b_i)
		rise && dir_up |=>
			stage_q[STAGES-1:1] == $past(stage_q[STAGES-2:0]);
	endproperty
	a_shift_up: assert property (p_shift_up)
		else $error("upward shift wrong");

	property p_shift_down;
		@(posedge clk_i) disable iff (!rst_b_i)
		rise && !dir_up |=>
			stage_q[STAGES-2:0] == $past(stage_q[STAGES-1:1]) &&
			stage_q[STAGES-1] == $past(serial_pin_b_i);
	endproperty
	a_shift_down: assert property (p_shift_down)
		else $error("downward shift wrong");

	property p_out_hold;
		@(posedge clk_i) disable iff (!rst_b_i)
		!fall |=> $stable(serial_out_q);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("serial output moved off a falling edge");

	property p_out_value;
		@(posedge clk_i) disable iff (!rst_b_i)
		fall |=> serial_out_q ==
			($past(dir_up) ? $past(stage_q[STAGES-1]) : $past(stage_q[0]));
	endproperty
	a_out_value: assert property (p_out_value)
		else $error("serial output not taken from last stage");

	property p_pin_roles;
		@(posedge clk_i) disable iff (!rst_b_i)
		dir_up |-> serial_pin_a_oe_b_o && !serial_pin_b_oe_b_o;
	endproperty
	a_pin_roles: assert property (p_pin_roles)
		else $error("pin roles wrong for upward scan");

	property p_clear_low;
		@(posedge clk_i) disable iff (!rst_b_i)
		output_clear_i |=> gate_outputs_o == '0;
	endproperty
	a_clear_low: assert property (p_clear_low)
		else $error("gate outputs not cleared");

	property p_follow;
		@(posedge clk_i) disable iff (!rst_b_i)
		!output_clear_i |=> gate_outputs_o == $past(stage_q);
	endproperty
	a_follow: assert property (p_follow)
		else $error("gate outputs do not follow stages");

	property p_clear_shifts;
		@(posedge clk_i) disable iff (!rst_b_i)
		output_clear_i && rise && dir_up |=>
			stage_q[STAGES-1:1] == $past(stage_q[STAGES-2:0]);
	endproperty
	a_clear_shifts: assert property (p_clear_shifts)
		else $error("shift stalled while cleared");

	// Port-level pin checks, so a miswired pin cannot hide; the stage hold and downward clear-shift checks look at the register
	property p_pin_roles_down;
		@(posedge clk_i) disable iff (!rst_b_i)
		!dir_up |-> !serial_pin_a_oe_b_o && serial_pin_b_oe_b_o;
	endproperty
	a_pin_roles_down: assert property (p_pin_roles_down)
		else $error("pin roles wrong for downward scan");

	property p_shift_hold;
		@(posedge clk_i) disable iff (!rst_b_i)
		!rise |=> stage_q == $past(stage_q);
	endproperty
	a_shift_hold: assert property (p_shift_hold)
		else $error("stages moved without a shift clock rise");

	property p_clear_shifts_down;
		@(posedge clk_i) disable iff (!rst_b_i)
		output_clear_i && rise && !dir_up |=>
			stage_q[STAGES-2:0] == $past(stage_q[STAGES-1:1]);
	endproperty
	a_clear_shifts_down: assert property (p_clear_shifts_down)
		else $error("downward shift stalled while cleared");

	property p_pin_b_out;
		@(posedge clk_i) disable iff (!rst_b_i)
		fall && dir_up |=> serial_pin_b_o == $past(stage_q[STAGES-1]);
	endproperty
	a_pin_b_out: assert property (p_pin_b_out)
		else $error("pin b did not carry the top stage");

	property p_pin_a_out;
		@(posedge clk_i) disable iff (!rst_b_i)
		fall && !dir_up |=> serial_pin_a_o == $past(stage_q[0]);
	endproperty
	a_pin_a_out: assert property (p_pin_a_out)
		else $error("pin a did not carry the bottom stage");

	property p_pins_hold;
		@(posedge clk_i) disable iff (!rst_b_i)
		!fall |=> $stable(serial_pin_a_o) && $stable(serial_pin_b_o);
	endproperty
	a_pins_hold: assert property (p_pins_hold)
		else $error("serial pin moved off a falling edge");
endmodule // gate_scan_shift_register

// ### testbench/scan_ctrl_model.sv
// Panel controller model: shift clock pulses and entry data
`timescale 1ns/1ps
module scan_ctrl_model (
	input  wire logic clk_i,
	input  wire logic run_i,
	input  wire logic data_i,
	output logic      shift_clock_o,
	output logic      data_o
);
	logic [1:0] ph_q = 2'h0;
	initial shift_clock_o = 1'b0;
	initial data_o = 1'b0;
	// Clock rests low between scans; data moves two cycles before a rise
	always @(negedge clk_i) begin
		ph_q <= run_i ? ph_q + 2'h1 : 2'h0;
		shift_clock_o <= run_i & ph_q[1];
		if (ph_q == 2'h0)
			data_o <= data_i;
	end
endmodule // scan_ctrl_model

// ### testbench/tb.sv
// Self-checking bench for the gate scan shift register
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
	mismatches++; $display("wrong value at %0t line %0d", $time, \
	`__LINE__); end end
module tb;
	import gate_scan_pkg::*;
	localparam int S = STAGE_COUNT;
	logic clk_i = 1'b0, rst_b_i = 1'b0, dir = DIR_UP, clr = 1'b0;
	logic run = 1'b0, dat = 1'b0, sc, md, a_o, a_oe_b, b_o, b_oe_b;
	logic [S-1:0] g, ref_q = '0, gexp = '0;
	logic sc_q = 1'b0, sexp = 1'b0;
	// Random source starts at 87645
	logic [16:0] rnd = 17'h1565D;
	int mismatches = 0, tests_run = 0, cyc = 0, t, i;
	always #12.5 clk_i = ~clk_i;
	function automatic logic [16:0] lfsr(logic [16:0] x);
		return {x[15:0], x[16] ^ x[13]};
	endfunction
	// Expected register after one shift in the given direction
	function automatic logic [S-1:0] shifted(logic up, logic [S-1:0] r,
		logic d);
		return up ? {r[S-2:0], d} : {d, r[S-1:1]};
	endfunction
	scan_ctrl_model ctrl (.clk_i(clk_i), .run_i(run), .data_i(dat),
		.shift_clock_o(sc), .data_o(md));
	// Each pin wire resolves to whoever has it enabled
	gate_scan_shift_register dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.shift_clock_i(sc), .direction_select_i(dir),
		.output_clear_i(clr),
		.serial_pin_a_i(a_oe_b ? md : a_o), .serial_pin_a_o(a_o),
		.serial_pin_a_oe_b_o(a_oe_b),
		.serial_pin_b_i(b_oe_b ? md : b_o), .serial_pin_b_o(b_o),
		.serial_pin_b_oe_b_o(b_oe_b), .gate_outputs_o(g));
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			sc_q <= 1'b0;
			ref_q <= '0;
			gexp <= '0;
			sexp <= 1'b0;
		end else begin
			sc_q <= sc;
			gexp <= clr ? '0 : ref_q;
			if (sc & ~sc_q)
				ref_q <= shifted(dir, ref_q, md);
			if (~sc & sc_q)
				sexp <= dir ? ref_q[S-1] : ref_q[0];
		end
	end
	always @(negedge clk_i) begin
		if (rst_b_i) begin
			cyc++;
			`CHK(g, gexp)
			`CHK({a_oe_b, b_oe_b}, {dir, ~dir})
			`CHK(dir ? b_o : a_o, sexp)
			if (cyc > 5000) begin
				mismatches++;
				conclude();
			end
		end
	end
	task automatic conclude;
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Tests 2 and 3 send a lone token so it can be seen leaving the far pin
	initial begin
		repeat (8) @(posedge clk_i);
		@(negedge clk_i) rst_b_i <= 1'b1;
		for (t = 0; t < 4; t++) begin
			// Mid-run reset clears the register so each token travels alone
			if (t == 2) begin
				rst_b_i <= 1'b0;
				dat <= 1'b0;
				repeat (2) @(negedge clk_i);
				rst_b_i <= 1'b1;
			end
			dir <= ~t[0];
			run <= 1'b1;
			for (i = 0; i < 4 * S + 40; i++) begin
				@(negedge clk_i);
				rnd = lfsr(rnd);
				dat <= t[1] ? i < 4 : rnd[0];
				clr <= ~t[1] & rnd[3] & rnd[7];
			end
			run <= 1'b0;
			repeat (8) @(negedge clk_i);
			$display("test %0d done", t);
		end
		conclude();
	end
endmodule // tb
